// File: verilog/bmcsp_pkg.sv
// Constants and types for the biphase-mark serial port.
// Behaviour
// - Device makes bit clock, open-drain output.
// - Frame select active-low open drain, low activates.
// - Transmit request: sample controller data, encode onto line.
// - Receive mode: detect, decode, output bits.
// - Receive bit valid at bit clock falling edge.
// - Transmit data sampled at bit clock rising.
// - Reset input active high restores reset state.
// - Transmit request overrides receive mode.
// - Transmit: frame select low first, then clock.
// - Request low: trailing edge, release line.
// - Line quiet: frame select returns high.
package bmcsp_pkg;

  localparam int CW = 12;

  // System clock rate and line bit timing
  localparam int CLK_MHZ   = 100;
  localparam int BIT_NS    = 3300;
  localparam int IDLE_NS   = 6600;
  localparam logic [CW-1:0] BIT_CYC =
    CW'((BIT_NS * CLK_MHZ) / 1000);
  localparam logic [CW-1:0] HALF_CYC  = CW'((BIT_NS * CLK_MHZ) / 2000);
  localparam logic [CW-1:0] THREEQ_CYC =
    CW'((BIT_NS * CLK_MHZ * 3) / 4000);
  localparam logic [CW-1:0] IDLE_CYC =
    CW'((IDLE_NS * CLK_MHZ) / 1000);

  // Bit buffer between line and controller
  localparam int FIFO_WIDTH = 1;
  localparam int FIFO_DEPTH = 32;

  // Pin drive: oe high drives level onto the wire; bit clock and frame select keep level low
  typedef struct packed {
    logic level;
    logic oe;
  } bmcsp_od_type;

  localparam bmcsp_od_type OD_RELEASED = '{level: 1'b0, oe: 1'b0};

  typedef enum logic [2:0] {
    ST_RX_IDLE,
    ST_RX_ACT,
    ST_TX_SEL,
    ST_TX_RUN,
    ST_TX_DRAIN,
    ST_TX_TAIL
  } bmcsp_state_type;

endpackage

// File: verilog/bmcsp_fifo.sv
// Bit FIFO with valid/ready on both sides and a flush.
`timescale 1ns/1ps
module bmcsp_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 32
) (
  // Clock and control
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             ce,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;
  logic             do_wr;
  logic             do_rd;

  assign in_ready  = (wr_ptr_r[AW-1:0] != rd_ptr_r[AW-1:0]) ||
                     (wr_ptr_r[AW] == rd_ptr_r[AW]);
  assign out_valid = (wr_ptr_r != rd_ptr_r);
  assign out_data  = mem[rd_ptr_r[AW-1:0]];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  always_ff @(posedge clk_sys) begin
    if (ce && do_wr) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || (ce && flush)) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else if (ce) begin
      if (do_wr) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

endmodule

// File: verilog/bmcsp_port.sv
// Serial port between the biphase-mark line and the controller.
`timescale 1ns/1ps
module bmcsp_port
  import bmcsp_pkg::*;
(
  // Clock, reset, enable
  input  wire logic   clk_sys,
  input  wire logic   reset,
  input  wire logic   ce,
  // Configuration channel line
  input  wire logic   cc_line_in,
  output bmcsp_od_type cc_line_drive,
  // Controller serial side
  input  wire logic   tx_line_drive_request,
  input  wire logic   encode_data_in,
  output logic        decoded_data_out,
  output bmcsp_od_type bit_clock,
  output bmcsp_od_type transfer_frame_select
);

  function automatic logic tx_state(input bmcsp_state_type s);
    tx_state = (s == ST_TX_SEL) || (s == ST_TX_RUN) ||
               (s == ST_TX_DRAIN) || (s == ST_TX_TAIL);
  endfunction

  function automatic logic [CW-1:0] step(input logic [CW-1:0] c);
    step = (c == {CW{1'b1}}) ? c : c + 1'b1;
  endfunction

  bmcsp_state_type state_r;

  // Pin synchronisers
  logic [1:0] cc_sync_r;
  logic [1:0] req_sync_r;
  logic [1:0] dat_sync_r;
  logic       cc_prev_r;
  logic       cc_edge;
  logic       req_s;
  logic       dat_s;

  // Decoder
  logic [CW-1:0] dcnt_r;
  logic          dec_armed_r;
  logic          half_pend_r;
  logic          dec_push_r;
  logic          dec_data_r;
  logic          line_quiet;

  // Controller-side bit slots
  logic          slot_busy_r;
  logic [CW-1:0] scnt_r;
  logic          tx_push_r;
  logic          tx_data_r;
  logic          rx_pop;
  logic          tx_start;
  logic          slot_end;

  // Encoder
  logic          enc_busy_r;
  logic [CW-1:0] ecnt_r;
  logic          enc_bit_r;
  logic          enc_pop;
  logic [CW-1:0] tail_cnt_r;

  // FIFO hookup
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_in_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic fifo_out_data;
  logic fifo_flush;

  assign cc_edge    = cc_sync_r[1] ^ cc_prev_r;
  assign req_s      = req_sync_r[1];
  assign dat_s      = dat_sync_r[1];
  assign line_quiet = (dcnt_r >= IDLE_CYC);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cc_sync_r  <= 2'h0;
      req_sync_r <= 2'h0;
      dat_sync_r <= 2'h0;
      cc_prev_r  <= 1'b0;
    end else if (ce) begin
      cc_sync_r  <= {cc_sync_r[0], cc_line_in};
      req_sync_r <= {req_sync_r[0], tx_line_drive_request};
      dat_sync_r <= {dat_sync_r[0], encode_data_in};
      cc_prev_r  <= cc_sync_r[1];
    end
  end

  // Mode sequencing and frame select
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_r               <= ST_RX_IDLE;
      transfer_frame_select <= OD_RELEASED;
      tail_cnt_r            <= '0;
    end else if (ce) begin
      case (state_r)
        ST_RX_IDLE: begin
          if (req_s) begin
            state_r                  <= ST_TX_SEL;
            transfer_frame_select.oe <= 1'b1;
            tail_cnt_r               <= '0;
          end else if (cc_edge) begin
            state_r                  <= ST_RX_ACT;
            transfer_frame_select.oe <= 1'b1;
          end
        end
        ST_RX_ACT: begin
          if (req_s) begin
            state_r    <= ST_TX_SEL;
            tail_cnt_r <= '0;
          end else if (line_quiet && !fifo_out_valid &&
                       !slot_busy_r) begin
            state_r                  <= ST_RX_IDLE;
            transfer_frame_select.oe <= 1'b0;
          end
        end
        ST_TX_SEL: begin
          tail_cnt_r <= step(tail_cnt_r);
          if (tail_cnt_r == HALF_CYC - 1'b1) begin
            state_r <= ST_TX_RUN;
          end
        end
        ST_TX_RUN: begin
          if (!req_s && !slot_busy_r) begin
            state_r <= ST_TX_DRAIN;
          end
        end
        ST_TX_DRAIN: begin
          if (!fifo_out_valid && !enc_busy_r) begin
            state_r    <= ST_TX_TAIL;
            tail_cnt_r <= '0;
          end
        end
        ST_TX_TAIL: begin
          tail_cnt_r <= step(tail_cnt_r);
          if (tail_cnt_r == HALF_CYC - 1'b1) begin
            state_r                  <= ST_RX_IDLE;
            transfer_frame_select.oe <= 1'b0;
          end
        end
        default: begin
          state_r                  <= ST_RX_IDLE;
          transfer_frame_select.oe <= 1'b0;
        end
      endcase
    end
  end

  // Biphase-mark decoder: long gap is a 0, two short gaps a 1
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dcnt_r      <= '0;
      dec_armed_r <= 1'b0;
      half_pend_r <= 1'b0;
      dec_push_r  <= 1'b0;
      dec_data_r  <= 1'b0;
    end else if (ce) begin
      dec_push_r <= 1'b0;
      if (tx_state(state_r)) begin
        dcnt_r      <= '0;
        dec_armed_r <= 1'b0;
        half_pend_r <= 1'b0;
      end else if (cc_edge) begin
        dcnt_r      <= '0;
        dec_armed_r <= 1'b1;
        if (dec_armed_r) begin
          if (dcnt_r >= THREEQ_CYC) begin
            dec_push_r  <= 1'b1;
            dec_data_r  <= 1'b0;
            half_pend_r <= 1'b0;
          end else if (half_pend_r) begin
            dec_push_r  <= 1'b1;
            dec_data_r  <= 1'b1;
            half_pend_r <= 1'b0;
          end else begin
            half_pend_r <= 1'b1;
          end
        end
      end else begin
        dcnt_r <= step(dcnt_r);
        if (line_quiet) begin
          dec_armed_r <= 1'b0;
          half_pend_r <= 1'b0;
        end
      end
    end
  end

  // One bit clock cycle per bit slot toward the controller
  // A new slot may start on the last count of the old one, so slots
  // follow each other at exactly one bit time
  assign slot_end = slot_busy_r && (scnt_r == BIT_CYC - 1'b1);
  assign rx_pop   = (state_r == ST_RX_ACT) && (!slot_busy_r || slot_end);
  // A full buffer stalls the clock instead of dropping controller bits
  assign tx_start = (state_r == ST_TX_RUN) && req_s &&
                    (!slot_busy_r || slot_end) && fifo_in_ready;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      slot_busy_r      <= 1'b0;
      scnt_r           <= '0;
      bit_clock        <= OD_RELEASED;
      decoded_data_out <= 1'b0;
      tx_push_r        <= 1'b0;
      tx_data_r        <= 1'b0;
    end else if (ce) begin
      tx_push_r <= 1'b0;
      if (!slot_busy_r || slot_end) begin
        scnt_r       <= '0;
        slot_busy_r  <= 1'b0;
        bit_clock.oe <= 1'b0;
        if (rx_pop && fifo_out_valid) begin
          slot_busy_r      <= 1'b1;
          decoded_data_out <= fifo_out_data;
        end else if (tx_start) begin
          slot_busy_r  <= 1'b1;
          bit_clock.oe <= 1'b1;
        end
      end else begin
        scnt_r <= scnt_r + 1'b1;
        if (scnt_r == HALF_CYC - 1'b1) begin
          // Only a slot opened in transmit has its clock low here; a
          // receive slot cut by a transmit request gives no edge at all
          if (bit_clock.oe) begin
            bit_clock.oe <= 1'b0;
            tx_push_r    <= 1'b1;
            tx_data_r    <= dat_s;
          end else if (!tx_state(state_r)) begin
            bit_clock.oe <= 1'b1;
          end
        end
      end
    end
  end

  // Biphase-mark encoder: edge at every boundary, mid edge for a 1
  // Chaining on the last count keeps each line bit exactly one bit time
  assign enc_pop = ((state_r == ST_TX_RUN) || (state_r == ST_TX_DRAIN)) &&
                   (!enc_busy_r || (ecnt_r == BIT_CYC - 1'b1));

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      enc_busy_r    <= 1'b0;
      ecnt_r        <= '0;
      enc_bit_r     <= 1'b0;
      cc_line_drive <= OD_RELEASED;
    end else if (ce) begin
      if (enc_pop && fifo_out_valid) begin
        enc_busy_r          <= 1'b1;
        ecnt_r              <= '0;
        enc_bit_r           <= fifo_out_data;
        cc_line_drive.oe    <= 1'b1;
        cc_line_drive.level <= ~cc_line_drive.level;
      end else if (enc_busy_r) begin
        ecnt_r <= ecnt_r + 1'b1;
        if (ecnt_r == HALF_CYC - 1'b1 && enc_bit_r) begin
          cc_line_drive.level <= ~cc_line_drive.level;
        end
        if (ecnt_r == BIT_CYC - 1'b1) begin
          enc_busy_r <= 1'b0;
        end
      end else if (state_r == ST_TX_TAIL) begin
        if (tail_cnt_r == '0) begin
          cc_line_drive.level <= ~cc_line_drive.level;
        end else if (tail_cnt_r == HALF_CYC - 1'b1) begin
          cc_line_drive <= OD_RELEASED;
        end
      end else if (!tx_state(state_r)) begin
        cc_line_drive <= OD_RELEASED;
      end
    end
  end

  // Buffer path shared by both directions; cleared when transmit starts
  assign fifo_flush     = (state_r == ST_TX_SEL) ||
                          (state_r == ST_RX_IDLE && req_s);
  assign fifo_in_valid  = tx_state(state_r) ? tx_push_r : dec_push_r;
  assign fifo_in_data   = tx_state(state_r) ? tx_data_r : dec_data_r;
  assign fifo_out_ready = tx_state(state_r) ? enc_pop : rx_pop;

  bmcsp_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .ce        (ce),
    .flush     (fifo_flush),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

endmodule

// File: sim/bmcsp_assertions.sv
// Port checker for the biphase-mark serial port.
`timescale 1ns/1ps
module bmcsp_chk
  import bmcsp_pkg::*;
(
  // Clock and reset
  input wire logic         clk_sys,
  input wire logic         reset,
  input wire logic         ce,
  // Line
  input wire logic         cc_line_in,
  input wire bmcsp_od_type cc_line_drive,
  // Controller side
  input wire logic         tx_line_drive_request,
  input wire logic         encode_data_in,
  input wire logic         decoded_data_out,
  input wire bmcsp_od_type bit_clock,
  input wire bmcsp_od_type transfer_frame_select
);
  logic [11:0] hi_r;
  logic [11:0] qt_r;
  logic        ln_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Length of the current low pulse on the bit clock wire
  always_ff @(posedge clk_sys) begin
    if (reset || !bit_clock.oe)
      hi_r <= 12'h000;
    else
      hi_r <= hi_r + 12'h001;
  end
  // Quiet time on the line, saturating
  always_ff @(posedge clk_sys) begin
    ln_r <= cc_line_in;
    if (reset || cc_line_in != ln_r)
      qt_r <= 12'h000;
    else if (qt_r != 12'hFFF)
      qt_r <= qt_r + 12'h001;
  end
  property p_bclk_od; bit_clock.level == 1'b0; endproperty
  a_bclk_od: assert property (p_bclk_od)
    else $error("clock level set");
  property p_fsel_od; transfer_frame_select.level == 1'b0; endproperty
  a_fsel_od: assert property (p_fsel_od)
    else $error("select level set");
  property p_rst;
    $fell(reset) |-> !bit_clock.oe && !transfer_frame_select.oe &&
      !cc_line_drive.oe && !decoded_data_out;
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset state wrong");
  property p_clk_frame;
    bit_clock.oe |-> transfer_frame_select.oe;
  endproperty
  a_clk_frame: assert property (p_clk_frame)
    else $error("clock outside frame");
  property p_sel_first;
    $rose(bit_clock.oe) |-> $past(transfer_frame_select.oe);
  endproperty
  a_sel_first: assert property (p_sel_first)
    else $error("clock before select");
  property p_clk_half;
    $fell(bit_clock.oe) |-> hi_r == HALF_CYC;
  endproperty
  a_clk_half: assert property (p_clk_half)
    else $error("clock pulse length");
  property p_dout_hold;
    bit_clock.oe |-> $stable(decoded_data_out);
  endproperty
  a_dout_hold: assert property (p_dout_hold)
    else $error("data moved");
  property p_line_frame;
    $rose(cc_line_drive.oe) |-> transfer_frame_select.oe;
  endproperty
  a_line_frame: assert property (p_line_frame)
    else $error("line without select");
  property p_quiet;
    $fell(transfer_frame_select.oe) |-> qt_r >= IDLE_CYC;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("select released early");
  property p_tx_end;
    $fell(cc_line_drive.oe) |-> !tx_line_drive_request;
  endproperty
  a_tx_end: assert property (p_tx_end)
    else $error("line released in transmit");
  c_rx: cover property ($fell(transfer_frame_select.oe));
  c_tx: cover property ($rose(cc_line_drive.oe));
  c_clk: cover property ($fell(bit_clock.oe));
endmodule
bind bmcsp_port bmcsp_chk u_chk (
  .clk_sys               (clk_sys),
  .reset                 (reset),
  .ce                    (ce),
  .cc_line_in            (cc_line_in),
  .cc_line_drive         (cc_line_drive),
  .tx_line_drive_request (tx_line_drive_request),
  .encode_data_in        (encode_data_in),
  .decoded_data_out      (decoded_data_out),
  .bit_clock             (bit_clock),
  .transfer_frame_select (transfer_frame_select)
);

// File: sim/bmcsp_mcu.sv
// Controller-side serial peripheral model.
`timescale 1ns/1ps
module bmcsp_mcu (
  // Wires from the port
  input  wire logic bclk_w,
  input  wire logic fsel_w,
  input  wire logic decoded_data_out,
  // Wires toward the port
  output logic      tx_line_drive_request,
  output logic      encode_data_in
);
  logic rx_q[$];
  initial begin
    tx_line_drive_request = 1'b0;
    encode_data_in = 1'b1;
  end
  // Receive bits are taken on the falling clock edge
  always @(negedge bclk_w) begin
    if (!fsel_w && !tx_line_drive_request)
      rx_q.push_back(decoded_data_out);
  end
  task automatic send(input logic [7:0] d);
    int i;
    tx_line_drive_request = 1'b1;
    encode_data_in = d[0];
    for (i = 1; i <= 8; i++) begin
      @(posedge bclk_w);
      #1;
      encode_data_in = (i < 8) ? d[i] : 1'b1;
    end
    tx_line_drive_request = 1'b0;
  endtask
endmodule

// File: sim/tb_top.sv
// Testbench for the biphase-mark serial port.
`timescale 1ns/1ps
`define CHK(a, e) begin \
  compares++; \
  if ((a) !== (e)) begin \
    n_errors++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, a, e); \
  end \
end
module tb_top;
  import bmcsp_pkg::*;
  logic         clk_sys;
  logic         reset;
  logic         ce;
  logic         cc_line_in;
  bmcsp_od_type cc_line_drive;
  bmcsp_od_type bit_clock;
  bmcsp_od_type transfer_frame_select;
  logic         decoded_data_out;
  logic         tx_line_drive_request;
  logic         encode_data_in;
  logic         bclk_w;
  logic         fsel_w;
  logic         prv;
  bit           iv[$];
  int           n_errors;
  int           compares;
  int           nf;
  int           cyc;
  int           last_t;
  // Open-drain wires with pull-ups
  assign bclk_w = !bit_clock.oe;
  assign fsel_w = !transfer_frame_select.oe;
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  bmcsp_port DUT (
    .clk_sys               (clk_sys),
    .reset                 (reset),
    .ce                    (ce),
    .cc_line_in            (cc_line_in),
    .cc_line_drive         (cc_line_drive),
    .tx_line_drive_request (tx_line_drive_request),
    .encode_data_in        (encode_data_in),
    .decoded_data_out      (decoded_data_out),
    .bit_clock             (bit_clock),
    .transfer_frame_select (transfer_frame_select)
  );
  bmcsp_mcu u_mcu (
    .bclk_w                (bclk_w),
    .fsel_w                (fsel_w),
    .decoded_data_out      (decoded_data_out),
    .tx_line_drive_request (tx_line_drive_request),
    .encode_data_in        (encode_data_in)
  );
  // Line toggles while driven: interval long or short
  always @(posedge clk_sys) begin
    cyc++;
    prv <= cc_line_drive.level;
    if (cc_line_drive.oe && cc_line_drive.level !== prv) begin
      iv.push_back((cyc - last_t) > 200);
      last_t = cyc;
    end
  end
  always @(negedge bclk_w) nf++;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_rel();
    int k;
    for (k = 0; k < 9000 && fsel_w !== 1'b1; k++) tick(1);
    `CHK(fsel_w, 1'b1)
  endtask
  task automatic bmc_line(input logic [7:0] d);
    int i;
    cc_line_in = ~cc_line_in;
    for (i = 0; i < 8; i++) begin
      if (d[i]) begin
        tick(165);
        cc_line_in = ~cc_line_in;
        tick(165);
      end else
        tick(330);
      cc_line_in = ~cc_line_in;
    end
  endtask
  task automatic t_reset();
    `CHK(bit_clock.oe, 1'b0)
    `CHK(transfer_frame_select.oe, 1'b0)
    `CHK(cc_line_drive.oe, 1'b0)
    `CHK(decoded_data_out, 1'b0)
    $display("test reset done");
  endtask
  task automatic t_ce_rst();
    cc_line_in = 1'b1;
    tick(6);
    `CHK(transfer_frame_select.oe, 1'b1)
    ce = 1'b0;
    tick(700);
    `CHK(transfer_frame_select.oe, 1'b1)
    ce = 1'b1;
    reset = 1'b1;
    cc_line_in = 1'b0;
    tick(3);
    reset = 1'b0;
    `CHK(transfer_frame_select.oe, 1'b0)
    `CHK(bit_clock.oe, 1'b0)
    tick(10);
    `CHK(transfer_frame_select.oe, 1'b0)
    $display("test enable and reset done");
  endtask
  task automatic t_rx(input logic [7:0] d);
    int i;
    u_mcu.rx_q.delete();
    nf = 0;
    bmc_line(d);
    wait_rel();
    `CHK(nf, 8)
    `CHK(u_mcu.rx_q.size(), 8)
    for (i = 0; i < 8; i++) `CHK(u_mcu.rx_q[i], d[i])
    $display("test receive %0h done", d);
  endtask
  task automatic t_tx(input logic [7:0] d);
    int i;
    iv.delete();
    fork
      bmc_line(8'h5A);
      begin
        tick(700);
        u_mcu.send(d);
        nf = 0;
      end
    join
    wait_rel();
    `CHK(nf, 0)
    `CHK(cc_line_drive.oe, 1'b0)
    void'(iv.pop_front());
    for (i = 0; i < 8; i++) begin
      if (d[i]) begin
        `CHK(iv.pop_front(), 1'b0)
        `CHK(iv.pop_front(), 1'b0)
      end else
        `CHK(iv.pop_front(), 1'b1)
    end
    `CHK(iv.size(), 0)
    $display("test transmit %0h done", d);
  endtask
  task automatic complete_run();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #400000;
    n_errors++;
    complete_run();
  end
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    cc_line_in = 1'b0;
    prv = 1'b0;
    n_errors = 0;
    compares = 0;
    nf = 0;
    cyc = 0;
    last_t = 0;
    tick(10);
    reset = 1'b0;
    t_reset();
    t_ce_rst();
    t_rx(8'hB4);
    t_rx(8'hFF);
    t_rx(8'h00);
    t_tx(8'hB4);
    t_tx(8'hC3);
    complete_run();
  end
endmodule
